// ### src/rxbsp_defs.vh
`ifndef RXBSP_DEFS_VH
`define RXBSP_DEFS_VH

// register byte offsets
`define RXBSP_REG_CTRL 8'h00
`define RXBSP_REG_STAT 8'h04
`define RXBSP_REG_OFS 8'h08

// control register bit positions
`define RXBSP_CTRL_STBY 0
`define RXBSP_CTRL_CAL 1
`define RXBSP_CTRL_RATE 2
`define RXBSP_CTRL_FMT 3
`define RXBSP_CTRL_DRV 4
`define RXBSP_CTRL_W 5

// control reset value: standby on, slow rate, single pin, drive off
`define RXBSP_CTRL_RST 5'h01

// word width
`define RXBSP_WORD_W 12

// wake-up delay in master cycles, single and split format
`define RXBSP_WAKE_SINGLE 6'h20
`define RXBSP_WAKE_SPLIT 6'h1F

// frame length in master cycles
`define RXBSP_FRM_SGL_SLOW 6'h18
`define RXBSP_FRM_SGL_FAST 6'h0C
`define RXBSP_FRM_SPL_SLOW 6'h30
`define RXBSP_FRM_SPL_FAST 6'h18

// bits per word, as a slot limit
`define RXBSP_BITS 6'h0C

// controller states
`define RXBSP_ST_SLEEP 2'h0
`define RXBSP_ST_WAIT 2'h1
`define RXBSP_ST_RUN 2'h2

`endif

// ### src/rxbsp_ofs.v
`include "rxbsp_defs.vh"

module rxbsp_ofs
#(
  parameter W = 12
)
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // calibration and filter results
  input wire cal,
  input wire valid,
  input wire [2*W-1:0] din,
  // corrected words and offsets
  output wire [2*W-1:0] dout,
  output wire [2*W-1:0] ofs
);

  // arms a load while calibration is high, fires on the first result after
  reg armed_ff;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_ff <= 1'b0;
    else if (cal)
      armed_ff <= 1'b1;
    else if (valid)
      armed_ff <= 1'b0;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      reg [W-1:0] ofs_ff;
      reg [W-1:0] cor_ff;
      wire [W-1:0] smp;
      wire load;
      assign smp = din[g*W +: W];
      assign load = valid & armed_ff & ~cal;
      // offset cleared during calibration, loaded by first result after
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ofs_ff <= {W{1'b0}};
        else if (cal)
          ofs_ff <= {W{1'b0}};
        else if (load)
          ofs_ff <= smp;
      end
      // offset subtracted from every result
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          cor_ff <= {W{1'b0}};
        else if (valid)
          cor_ff <= smp - (load ? smp : ofs_ff);
      end
      assign dout[g*W +: W] = cor_ff;
      assign ofs[g*W +: W] = ofs_ff;
    end
  endgenerate

endmodule

// ### src/rxbsp_top.v
// Overview of operation
// - standby level is sampled on the master clock rising edge.
// - serial clock starts 32 (single) or 31 (split) master cycles after release.
// - serial clock period is one master cycle single, two master cycles split.
// - serial clock rises together with the master clock rising edge.
// - frame sync is high one master cycle single, two split.
// - frame repeats 24/12 master cycles single, 48/24 split, slow/fast.
// - frame sync is valid before a serial clock falling edge; host samples there.
// - data launched at serial clock rise; split format one master cycle later.
// - single format drives a channel indicator updated at serial clock rise.
// - frame sync marks the I word start; the Q word follows in single format, runs alongside in split.
// - standby raised shortly after a sync lets the following pair finish first.
// - single format uses one data pin; split uses separate I and Q pins.
// - offsets clear during calibration, load first result after, then subtract.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`include "rxbsp_defs.vh"

module rxbsp_top
(
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_RESETN,
  // wishbone slave
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  // filter results
  input wire I_WORD_VALID,
  input wire [11:0] I_I_WORD,
  input wire [11:0] I_Q_WORD,
  // serial link
  output reg O_SER_CLK,
  output reg O_FRAME_SYNC,
  output reg O_SERIAL_OUT,
  output reg O_INPHASE_SERIAL_OUT,
  output reg O_QUADRATURE_SERIAL_OUT,
  output reg O_CHAN_IS_I,
  output reg O_DATA_OE
);

  reg [`RXBSP_CTRL_W-1:0] ctrl_ff;
  reg ph_ff;
  reg stby_ff;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [5:0] dly_ff;
  reg [5:0] mc_ff;
  reg [5:0] nxt_mc;
  reg fmt_ff;
  reg rate_ff;
  reg wsel_ff;
  reg stop_ff;
  reg [11:0] cap_i_ff;
  reg [11:0] cap_q_ff;
  wire [23:0] cor;
  wire [23:0] ofs;
  wire req;
  wire wr;
  wire mstart;
  wire [5:0] flen;
  wire [5:0] wake;
  wire [5:0] slot;
  wire [3:0] bidx;
  wire [5:0] sq;
  wire [3:0] qidx;
  wire frm_end;
  wire last_frm;
  wire cap_now;
  wire [11:0] cur_i;
  wire [11:0] cur_q;

  // offset calibration and subtraction per channel
  rxbsp_ofs #(.W(`RXBSP_WORD_W)) u_ofs
  (
    .clk(I_CLK_SYS),
    .rst_n(I_RESETN),
    .cal(ctrl_ff[`RXBSP_CTRL_CAL]),
    .valid(I_WORD_VALID),
    .din({I_Q_WORD, I_I_WORD}),
    .dout(cor),
    .ofs(ofs)
  );

  // bus request decode
  assign req = I_WB_CYC & I_WB_STB;
  assign wr = req & I_WB_WE & O_WB_ACK;

  // wishbone ack and read data, one wait state
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else
    begin
      O_WB_ACK <= req & ~O_WB_ACK;
      case (I_WB_ADR)
        `RXBSP_REG_CTRL: O_WB_DAT <= {27'h000_0000, ctrl_ff};
        `RXBSP_REG_STAT: O_WB_DAT <= {29'h0000_0000, stop_ff, st_ff};
        `RXBSP_REG_OFS: O_WB_DAT <= {4'h0, ofs[23:12], 4'h0, ofs[11:0]};
        default: O_WB_DAT <= 32'h0000_0000;
      endcase
    end
  end

  // control register, written at the ack edge through byte lane 0
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
      ctrl_ff <= `RXBSP_CTRL_RST;
    else if (wr && I_WB_ADR == `RXBSP_REG_CTRL && I_WB_SEL[0])
      ctrl_ff <= I_WB_DAT[`RXBSP_CTRL_W-1:0];
  end

  // two system cycles make one master cycle; mstart marks its rising edge
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
      ph_ff <= 1'b0;
    else
      ph_ff <= ~ph_ff;
  end
  assign mstart = ph_ff;

  // standby sampled only at the master rising edge
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
      stby_ff <= 1'b1;
    else if (mstart)
      stby_ff <= ctrl_ff[`RXBSP_CTRL_STBY];
  end

  // frame geometry from latched format and rate; wake delay from the unlatched control format bit
  assign flen = fmt_ff ? (rate_ff ? `RXBSP_FRM_SPL_FAST : `RXBSP_FRM_SPL_SLOW)
                       : (rate_ff ? `RXBSP_FRM_SGL_FAST : `RXBSP_FRM_SGL_SLOW);
  assign wake = ctrl_ff[`RXBSP_CTRL_FMT] ? `RXBSP_WAKE_SPLIT : `RXBSP_WAKE_SINGLE;
  assign frm_end = (mc_ff == flen - 6'h01);
  assign last_frm = ~(~fmt_ff & rate_ff) | wsel_ff;

  // sequencer next state
  always @*
  begin
    nxt_st = st_ff;
    nxt_mc = mc_ff;
    case (st_ff)
      `RXBSP_ST_SLEEP:
      begin
        nxt_mc = 6'h00;
        if (mstart && !ctrl_ff[`RXBSP_CTRL_STBY])
          nxt_st = `RXBSP_ST_WAIT;
      end
      `RXBSP_ST_WAIT:
      begin
        nxt_mc = 6'h00;
        if (mstart && ctrl_ff[`RXBSP_CTRL_STBY])
          nxt_st = `RXBSP_ST_SLEEP;
        else if (mstart && dly_ff == wake - 6'h01)
          nxt_st = `RXBSP_ST_RUN;
      end
      `RXBSP_ST_RUN:
      begin
        if (mstart)
        begin
          nxt_mc = frm_end ? 6'h00 : mc_ff + 6'h01;
          if (frm_end && stop_ff && last_frm)
            nxt_st = `RXBSP_ST_SLEEP;
        end
      end
      default:
      begin
        nxt_st = `RXBSP_ST_SLEEP;
        nxt_mc = 6'h00;
      end
    endcase
  end

  // sequencer registers, wake counter, pair selection and stop request
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      st_ff <= `RXBSP_ST_SLEEP;
      mc_ff <= 6'h00;
      dly_ff <= 6'h00;
      fmt_ff <= 1'b0;
      rate_ff <= 1'b0;
      wsel_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      mc_ff <= nxt_mc;
      if (st_ff != `RXBSP_ST_WAIT)
        dly_ff <= 6'h00;
      else if (mstart)
        dly_ff <= dly_ff + 6'h01;
      // latched on wake so the first run edge already sees the new format
      if (st_ff == `RXBSP_ST_SLEEP && nxt_st == `RXBSP_ST_WAIT)
      begin
        fmt_ff <= ctrl_ff[`RXBSP_CTRL_FMT];
        rate_ff <= ctrl_ff[`RXBSP_CTRL_RATE];
        wsel_ff <= 1'b0;
      end
      else if (st_ff == `RXBSP_ST_RUN && mstart && frm_end)
        wsel_ff <= ~wsel_ff;
      if (st_ff != `RXBSP_ST_RUN)
        stop_ff <= 1'b0;
      else if (mstart && ctrl_ff[`RXBSP_CTRL_STBY])
        stop_ff <= 1'b1;
    end
  end

  // pair start; in single format the first bit leaves at this same edge, so it bypasses the capture
  assign cap_now = mstart && nxt_st == `RXBSP_ST_RUN && nxt_mc == 6'h00
                   && (fmt_ff != ctrl_ff[`RXBSP_CTRL_FMT] || st_ff != `RXBSP_ST_RUN
                       || last_frm);
  assign cur_i = cap_now ? cor[11:0] : cap_i_ff;
  assign cur_q = cap_now ? cor[23:12] : cap_q_ff;

  // words captured at each frame start that opens a new pair
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      cap_i_ff <= 12'h000;
      cap_q_ff <= 12'h000;
    end
    else if (cap_now)
    begin
      cap_i_ff <= cor[11:0];
      cap_q_ff <= cor[23:12];
    end
  end

  // bit slot of the master cycle about to begin
  assign slot = fmt_ff ? {1'b0, nxt_mc[5:1]} : nxt_mc;
  assign sq = slot - `RXBSP_BITS;
  assign bidx = 4'hB - slot[3:0];
  assign qidx = 4'hB - sq[3:0];

  // serial clock, frame sync, data and channel indicator
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_SER_CLK <= 1'b0;
      O_FRAME_SYNC <= 1'b0;
      O_SERIAL_OUT <= 1'b0;
      O_INPHASE_SERIAL_OUT <= 1'b0;
      O_QUADRATURE_SERIAL_OUT <= 1'b0;
      O_CHAN_IS_I <= 1'b0;
      O_DATA_OE <= 1'b0;
    end
    else
    begin
      O_DATA_OE <= ctrl_ff[`RXBSP_CTRL_DRV];
      if (nxt_st != `RXBSP_ST_RUN || (st_ff != `RXBSP_ST_RUN && !mstart))
      begin
        O_SER_CLK <= 1'b0;
        O_FRAME_SYNC <= 1'b0;
      end
      else if (!fmt_ff)
      begin
        // single pin: clock follows the master clock, data moves with its rise
        O_SER_CLK <= mstart;
        if (mstart)
        begin
          O_FRAME_SYNC <= (nxt_mc == 6'h00);
          if (rate_ff)
          begin
            O_SERIAL_OUT <= wsel_ff ^ frm_end ? cur_q[bidx] : cur_i[bidx];
            O_CHAN_IS_I <= ~(wsel_ff ^ frm_end);
          end
          else if (slot < `RXBSP_BITS)
          begin
            O_SERIAL_OUT <= cur_i[bidx];
            O_CHAN_IS_I <= 1'b1;
          end
          else
          begin
            O_SERIAL_OUT <= cur_q[qidx];
            O_CHAN_IS_I <= 1'b0;
          end
        end
      end
      else if (mstart)
      begin
        // split pins: clock high on even master cycles of the burst
        O_SER_CLK <= ~nxt_mc[0] & (slot < `RXBSP_BITS);
        O_FRAME_SYNC <= (nxt_mc < 6'h02);
        if (nxt_mc[0] && slot < `RXBSP_BITS)
        begin
          O_INPHASE_SERIAL_OUT <= cap_i_ff[bidx];
          O_QUADRATURE_SERIAL_OUT <= cap_q_ff[bidx];
        end
      end
    end
  end

endmodule

// ### tb/rx_baseband_serial_port_tb.sv
module rx_baseband_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic rate; logic fmt; logic [11:0] i; logic [11:0] q;} rxbsp_row_t;
  rxbsp_row_t rows[4] = '{'{1'b0, 1'b0, 12'h5A3, 12'hA5C}, '{1'b1, 1'b0, 12'h801, 12'h7FE},
    '{1'b0, 1'b1, 12'h123, 12'hFED}, '{1'b1, 1'b1, 12'h7FF, 12'h800}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic vld = 1'b0;
  logic vld_en = 1'b0;
  logic split = 1'b0;
  logic [11:0] iw = 12'h000;
  logic [11:0] qw = 12'h000;
  logic [31:0] rdat;
  logic ack, sclk, sync, sdat, idat, qdat, chan, oe;
  logic [11:0] m_i, m_q;
  int pairs;
  int errors = 0;
  int n_compared = 0;
  // clock and filter result strobe
  always #20 clk = ~clk;
  always @(posedge clk) vld <= vld_en & ~vld;
  rxbsp_top rxbsp_top_i (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_WORD_VALID(vld), .I_I_WORD(iw), .I_Q_WORD(qw), .O_SER_CLK(sclk),
    .O_FRAME_SYNC(sync), .O_SERIAL_OUT(sdat), .O_INPHASE_SERIAL_OUT(idat),
    .O_QUADRATURE_SERIAL_OUT(qdat), .O_CHAN_IS_I(chan), .O_DATA_OE(oe));
  rxbsp_dsp_model rxbsp_dsp_model_i (.i_clk(clk), .i_split(split), .i_ser_clk(sclk),
    .i_sync(sync), .i_sdat(sdat), .i_idat(idat), .i_qdat(qdat), .i_chan(chan),
    .o_i_word(m_i), .o_q_word(m_q), .o_pairs(pairs));
  task print_verdict;
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task bail;
    errors++;
    print_verdict();
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    if (k >= 20)
      bail();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wait_pairs;
    int n;
    int k;
    n = pairs + 3;
    k = 0;
    while (pairs < n && k < 1500)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 1500)
      bail();
  endtask
  initial
  begin
    logic [31:0] r;
    int n;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h0C, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
    chk("oe reset", 32'(oe), 32'h0000_0000);
    vld_en <= 1'b1;
    // each format and rate: wake delay, words, stop
    foreach (rows[j])
    begin
      split <= rows[j].fmt;
      iw <= rows[j].i;
      qw <= rows[j].q;
      wb(1'b1, 8'h00, {27'h0, 1'b1, rows[j].fmt, rows[j].rate, 2'b00}, r);
      n = 0;
      while (sclk !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      chk("wake", 32'((n - (rows[j].fmt ? 62 : 64)) inside {[1:3]}), 1);
      wait_pairs();
      chk("i word", m_i, rows[j].i);
      chk("q word", m_q, rows[j].q);
      wb(1'b1, 8'h00, 32'h0000_0001, r);
      n = 0;
      do
      begin
        wb(1'b0, 8'h04, 32'h0000_0000, r);
        n++;
      end
      while (r[1:0] !== 2'h0 && n < 100);
      chk("stopped", r[1:0], 0);
    end
    // calibration: offsets clear, load, then subtract
    split <= 1'b0;
    iw <= 12'h040;
    qw <= 12'hFC0;
    wb(1'b1, 8'h00, 32'h0000_0003, r);
    repeat (1220) @(posedge clk);
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("ofs cal", r, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0001, r);
    repeat (8) @(posedge clk);
    iw <= 12'h045;
    qw <= 12'hFBD;
    wb(1'b0, 8'h08, 32'h0000_0000, r);
    chk("ofs", r, 32'h0FC0_0040);
    wb(1'b1, 8'h00, 32'h0000_0010, r);
    wait_pairs();
    chk("i corr", m_i, 12'h005);
    chk("q corr", m_q, 12'hFFD);
    chk("drive oe", 32'(oe), 32'h0000_0001);
    print_verdict();
  end
endmodule

// ### tb/rxbsp_dsp_model.sv
module rxbsp_dsp_model
(
  // sys clock and format
  input wire logic i_clk,
  input wire logic i_split,
  // link pins
  input wire logic i_ser_clk,
  input wire logic i_sync,
  input wire logic i_sdat,
  input wire logic i_idat,
  input wire logic i_qdat,
  input wire logic i_chan,
  // captured words
  output logic [11:0] o_i_word,
  output logic [11:0] o_q_word,
  output int o_pairs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] sh_i;
  logic [11:0] sh_q;
  logic [5:0] p;
  int n;
  initial o_pairs = 0;
  // sync, single data and channel pins as they stood just before a serial clock fall are taken
  always @(posedge i_clk)
  begin
    if (p[5] && !i_ser_clk)
    begin
      if (p[4])
        n = 0;
      n++;
      // split data moves at the fall, so the value just launched is taken
      sh_i = {sh_i[10:0], i_split ? i_idat : p[3]};
      sh_q = {sh_q[10:0], i_split ? i_qdat : p[1]};
      if (i_split && n == 12)
      begin
        o_i_word = sh_i;
        o_q_word = sh_q;
        o_pairs++;
      end
      else if (!i_split && (n == 12 || n == 24))
      begin
        if (p[0])
          o_i_word = sh_i;
        else
        begin
          o_q_word = sh_i;
          o_pairs++;
        end
      end
    end
    p = {i_ser_clk, i_sync, i_sdat, i_idat, i_qdat, i_chan};
  end
endmodule

// ### tb/rxbsp_top_asserts.sv
module rxbsp_top_asserts
(
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_RESETN,
  // serial link
  input wire O_SER_CLK,
  input wire O_FRAME_SYNC,
  input wire O_SERIAL_OUT,
  input wire O_INPHASE_SERIAL_OUT,
  input wire O_QUADRATURE_SERIAL_OUT,
  input wire O_CHAN_IS_I
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gap_ff;
  logic sync_d_ff;
  // sys cycles since the last frame sync rise, saturating
  always @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      gap_ff <= 8'hFF;
      sync_d_ff <= 1'b0;
    end
    else
    begin
      sync_d_ff <= O_FRAME_SYNC;
      if (O_FRAME_SYNC && !sync_d_ff)
        gap_ff <= 8'h01;
      else if (gap_ff > 8'd96)
        gap_ff <= 8'hFF; // longest frame passed: link restarts fresh
      else
        gap_ff <= gap_ff + 8'h01;
    end
  end
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_sync_rise;
    $rose(O_FRAME_SYNC);
  endsequence
  sequence s_clk_rise;
    $rose(O_SER_CLK);
  endsequence
  // frame sync rises with the clock, so it stands before the fall
  a_sync_on_clk: assert property (s_sync_rise |-> O_SER_CLK)
    else $error("frame sync rose with serial clock low");
  a_sync_width: assert property (s_sync_rise |-> O_FRAME_SYNC[*2] ##1
    (!O_FRAME_SYNC or O_FRAME_SYNC[*2] ##1 !O_FRAME_SYNC))
    else $error("frame sync width wrong");
  a_clk_high: assert property (s_clk_rise |-> ##[1:2] !O_SER_CLK)
    else $error("serial clock high too long");
  a_split_low: assert property (O_SER_CLK[*2] ##1 !O_SER_CLK |=> !O_SER_CLK)
    else $error("split serial clock low too short");
  a_frame_gap: assert property (s_sync_rise and gap_ff < 8'd200 |->
    gap_ff inside {8'd24, 8'd48, 8'd96})
    else $error("frame sync spacing wrong");
  a_sdat_launch: assert property ($changed(O_SERIAL_OUT) |-> $rose(O_SER_CLK))
    else $error("single data moved off clock rise");
  a_split_launch: assert property ($changed(O_INPHASE_SERIAL_OUT) ||
    $changed(O_QUADRATURE_SERIAL_OUT) |-> $fell(O_SER_CLK))
    else $error("split data moved off clock fall");
  a_chan_update: assert property ($changed(O_CHAN_IS_I) |-> $rose(O_SER_CLK))
    else $error("channel flag moved off clock rise");
endmodule

bind rxbsp_top rxbsp_top_asserts rxbsp_top_asserts_i (.I_CLK_SYS, .I_RESETN,
  .O_SER_CLK, .O_FRAME_SYNC, .O_SERIAL_OUT, .O_INPHASE_SERIAL_OUT,
  .O_QUADRATURE_SERIAL_OUT, .O_CHAN_IS_I);
